// File: testbench/hdlcr_tx_model.sv
// far-end serial transmitter model: flags, zero insertion, fcs
`timescale 1ns/1ps
module hdlcr_tx_model (
  input wire logic core_clk,
  output logic rxBit,
  output logic rxBitValid
);
  logic [15:0] crcReg; // running fcs of the frame body
  int ones; // run of ones since last zero
  // line starts quiet
  initial begin
    rxBit = 1'b0;
    rxBitValid = 1'b0;
    crcReg = hdlcr_pkg::CRC_INIT;
    ones = 0;
  end
  // one bit, strobe high for one cycle, line flips between bits
  task automatic put_bit(input logic b);
    @(negedge core_clk);
    rxBit = b;
    rxBitValid = 1'b1;
    @(negedge core_clk);
    rxBitValid = 1'b0;
    rxBit = ~b;
  endtask
  // body bit with crc update and zero insertion
  task automatic data_bit(input logic b, input logic fcsOn);
    if (fcsOn) begin
      crcReg = (crcReg >> 1) ^ ((crcReg[0] ^ b) ? hdlcr_pkg::CRC_POLY : 16'h0000);
    end
    put_bit(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin // stuffed zero after five ones
      put_bit(1'b0);
      ones = 0;
    end
  endtask
  // unstuffed pattern, lsb first; restarts the fcs
  task automatic send_raw(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) put_bit(v[i]);
    ones = 0;
    crcReg = hdlcr_pkg::CRC_INIT;
  endtask
  // body bits, lsb first
  task automatic send_byte(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) data_bit(v[i], 1'b1);
  endtask
  // inverted fcs, lsb first, optionally spoiled
  task automatic send_fcs(input logic corrupt);
    logic [15:0] f;
    f = ~crcReg ^ {15'h0000, corrupt};
    for (int i = 0; i < 16; i++) data_bit(f[i], 1'b0);
  endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench for the hdlc packet receiver
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst_n, softLinkReset, receiveEnable, addrMatchEnable, sevenBitCompare;
  logic [7:0] addrCmpFirst, addrCmpSecond, fifoData;
  logic [15:0] rxCrc, lastCrc; // lastCrc: sender crc, first sent bit at msb
  logic rxBit, rxBitValid, fifoRead, firstByteTag, lastByteTag, fifoNotEmpty;
  logic endWrittenIrq, endReadIrq, frameActive, idleChannel, goAheadSeen, fifoStall;
  int nMismatch, totalChecks, gotN, frmLen; // counters and lengths
  logic [10:0] gotE [0:39]; // end-read flag, tag, data per popped entry
  logic [7:0] frm [0:23]; // frame body to send
  hdlc_packet_receiver dut (.core_clk(core_clk), .rst_n(rst_n), .soft_link_reset(softLinkReset),
    .receive_enable(receiveEnable), .addr_match_enable(addrMatchEnable), .seven_bit_compare(sevenBitCompare),
    .addr_cmp_first(addrCmpFirst), .addr_cmp_second(addrCmpSecond), .rx_bit(rxBit), .rx_bit_valid(rxBitValid),
    .fifo_read(fifoRead), .fifo_data(fifoData), .first_byte_tag(firstByteTag), .last_byte_tag(lastByteTag),
    .fifo_not_empty(fifoNotEmpty), .end_written_irq(endWrittenIrq), .end_read_irq(endReadIrq), .rx_crc(rxCrc),
    .frame_active(frameActive), .idle_channel(idleChannel), .go_ahead_seen(goAheadSeen), .fifo_stall(fifoStall));
  hdlcr_tx_model farEnd (.core_clk(core_clk), .rxBit(rxBit), .rxBitValid(rxBitValid));
  // 40 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic print_verdict();
    if (nMismatch == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // pop until empty, status taken before each pop
  task automatic drain();
    gotN = 0;
    while (fifoNotEmpty === 1'b1 && gotN < 40) begin
      gotE[gotN] = {endReadIrq, lastByteTag, firstByteTag, fifoData};
      gotN++;
      fifoRead = 1'b1;
      cyc(1);
      fifoRead = 1'b0;
      cyc(2);
    end
    if (gotN >= 40) begin // fifo never empties
      nMismatch++;
      print_verdict();
    end
  endtask
  // opening flag, body, optional tail bits and fcs, closing flag
  task automatic send_frame(input logic corrupt, input logic withFcs, input int tail);
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    for (int i = 0; i < frmLen; i++) farEnd.send_byte(frm[i], 8);
    if (tail > 0) farEnd.send_byte(8'h05, tail);
    lastCrc = {<<{farEnd.crcReg}};
    if (withFcs) farEnd.send_fcs(corrupt);
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    cyc(8);
  endtask
  // drain and compare against frm
  task automatic check_frame(input int n, input logic [1:0] endTag, input logic hasEnd);
    logic lastOne;
    drain();
    chk(16'(gotN), 16'(n));
    for (int i = 0; i < gotN && i < n; i++) begin
      lastOne = (i == n - 1) && hasEnd;
      chk(gotE[i][7:0], frm[i]);
      chk(gotE[i][9:8], (i == 0) ? hdlcr_pkg::TAG_FIRST : lastOne ? endTag : hdlcr_pkg::TAG_BODY);
      chk(gotE[i][10], lastOne);
    end
  endtask
  // good frame with stuffing-heavy bytes, filter off
  task automatic sc_good();
    frm[0] = 8'h45;
    frm[1] = 8'hFF;
    frm[2] = 8'h7E;
    frm[3] = 8'h3F;
    frmLen = 4;
    send_frame(1'b0, 1'b1, 0);
    chk(endWrittenIrq, 1'b1);
    chk(rxCrc, lastCrc);
    check_frame(4, hdlcr_pkg::TAG_GOOD, 1'b1);
  endtask
  // spoiled fcs gives bad end
  task automatic sc_bad();
    frmLen = 3;
    send_frame(1'b1, 1'b1, 0);
    check_frame(3, hdlcr_pkg::TAG_BAD, 1'b1);
  endtask
  // 24 bits dropped, 28 bits give a first byte
  task automatic sc_short();
    frmLen = 3;
    send_frame(1'b0, 1'b0, 0);
    check_frame(0, hdlcr_pkg::TAG_BAD, 1'b1);
    send_frame(1'b0, 1'b0, 4);
    drain();
    chk(16'(gotN != 0), 16'h0001);
    chk(gotE[0][9:0], {hdlcr_pkg::TAG_FIRST, frm[0]});
  endtask
  // seven ones inside a 32-bit frame
  task automatic sc_abort();
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    for (int i = 0; i < 4; i++) farEnd.send_byte(8'h11 * (i + 1), 8);
    farEnd.send_raw(8'h7F, 7);
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    cyc(8);
    drain();
    chk(16'(gotN != 0), 16'h0001);
    if (gotN > 0) chk(gotE[gotN - 1][9:8], hdlcr_pkg::TAG_BAD);
  endtask
  // address filter cases: seven-bit option, first byte, second byte, accepted
  task automatic sc_addr();
    logic [17:0] tab [0:7];
    logic acc;
    tab = '{{1'b0, 8'h85, 8'h11, 1'b1}, {1'b0, 8'h87, 8'h11, 1'b1}, {1'b1, 8'h87, 8'h11, 1'b0},
      {1'b0, 8'h45, 8'h11, 1'b0}, {1'b0, 8'hFF, 8'h11, 1'b1}, {1'b0, 8'h86, 8'h13, 1'b1},
      {1'b0, 8'h44, 8'hFF, 1'b1}, {1'b0, 8'h84, 8'h15, 1'b0}};
    addrMatchEnable = 1'b1;
    for (int k = 0; k < 8; k++) begin
      {sevenBitCompare, frm[0], frm[1], acc} = tab[k];
      frm[2] = 8'h03;
      frmLen = 3;
      send_frame(1'b0, 1'b1, 0);
      check_frame(acc ? 3 : 0, hdlcr_pkg::TAG_GOOD, 1'b1);
    end
    addrMatchEnable = 1'b0;
    sevenBitCompare = 1'b0;
  endtask
  // 20 bytes into 16 entries with no reads
  task automatic sc_overflow();
    for (int i = 0; i < 20; i++) frm[i] = 8'(i) + 8'h10;
    frmLen = 20;
    send_frame(1'b0, 1'b1, 0);
    chk(fifoStall, 1'b1);
    check_frame(16, hdlcr_pkg::TAG_GOOD, 1'b0);
  endtask
  // disabled, enabled mid-frame, drained while disabled
  task automatic sc_enable();
    receiveEnable = 1'b0;
    frmLen = 3;
    send_frame(1'b0, 1'b1, 0);
    check_frame(0, hdlcr_pkg::TAG_GOOD, 1'b1);
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    farEnd.send_byte(frm[0], 8);
    receiveEnable = 1'b1;
    farEnd.send_byte(frm[1], 8);
    farEnd.send_byte(frm[2], 8);
    farEnd.send_fcs(1'b0);
    farEnd.send_raw(hdlcr_pkg::FLAG_PAT, 8);
    cyc(8);
    check_frame(0, hdlcr_pkg::TAG_GOOD, 1'b1);
    send_frame(1'b0, 1'b1, 0);
    receiveEnable = 1'b0;
    cyc(4);
    chk(frameActive, 1'b0);
    check_frame(3, hdlcr_pkg::TAG_GOOD, 1'b1);
    receiveEnable = 1'b1;
  endtask
  // idle ones, go-ahead, soft reset clears the fifo
  task automatic sc_line();
    farEnd.send_raw(8'hFF, 8);
    farEnd.send_raw(8'hFF, 8);
    cyc(2);
    chk(idleChannel, 1'b1);
    farEnd.send_raw(8'hFE, 8);
    farEnd.send_raw(8'h00, 1);
    cyc(2);
    chk(goAheadSeen, 1'b1);
  endtask
  task automatic sc_reset();
    frmLen = 3;
    send_frame(1'b0, 1'b1, 0);
    softLinkReset = 1'b1;
    cyc(1);
    softLinkReset = 1'b0;
    cyc(2);
    chk(fifoNotEmpty, 1'b0);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    softLinkReset = 1'b0;
    receiveEnable = 1'b0;
    addrMatchEnable = 1'b0;
    sevenBitCompare = 1'b0;
    addrCmpFirst = 8'h85;
    addrCmpSecond = 8'h13;
    fifoRead = 1'b0;
    nMismatch = 0;
    totalChecks = 0;
    cyc(2);
    rst_n = 1'b1;
    chk({fifoNotEmpty, endWrittenIrq, endReadIrq, fifoStall}, 16'h0000);
    receiveEnable = 1'b1;
    sc_line();
    sc_good();
    sc_bad();
    sc_short();
    sc_abort();
    sc_addr();
    sc_overflow();
    sc_good();
    sc_enable();
    sc_reset();
    print_verdict();
  end
endmodule

// File: verilog/hdlc_packet_receiver.sv
// hdlc receive path: flag hunt, zero deletion, crc check, address filter, tagged fifo
// What this block does
// - scan for go-ahead, flag and idle ones
// - flag aligns bytes and restarts crc
// - under 25 bits: frame discarded entirely
// - 25 to 31 bits: first byte, bad end
// - residue F0B8 at closing flag means good
// - address filter only when enabled, per-byte enables
// - extension bit 0: two bytes, six bits compared
// - all-call second byte skips first byte check
// - extension 1: one byte, all-call or match
// - seven-bit option widens single byte compare
// - tags 11 bad, 01 first, 10 good, 00
// - status reflects byte at fifo output
// - end-written flag on last stored end byte
// - end-read flag when output byte ends packet
// - last sixteen bits withheld as check sequence
// - overflow drops rest of packet until flag
// - no end tag after overflow truncation
// - enable at once, disable after packet stored
// - enabled mid-frame waits for a flag
// - fifo and status readable while disabled
// - received crc captured inverted, msb first
// - seven ones abort frame of 26+ bits
// - fifo entry is byte plus tag
`timescale 1ns/1ps
module hdlc_packet_receiver (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic soft_link_reset,
  input wire logic receive_enable,
  input wire logic addr_match_enable,
  input wire logic seven_bit_compare,
  input wire logic [7:0] addr_cmp_first,
  input wire logic [7:0] addr_cmp_second,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic fifo_read,
  output logic [7:0] fifo_data,
  output logic first_byte_tag,
  output logic last_byte_tag,
  output logic fifo_not_empty,
  output logic end_written_irq,
  output logic end_read_irq,
  output logic [15:0] rx_crc,
  output logic frame_active,
  output logic idle_channel,
  output logic go_ahead_seen,
  output logic fifo_stall
);
  // all receiver state
  typedef struct packed {
    hdlcr_pkg::hdlcr_state_t st;
    logic [8:0] shf;          // raw bit history, newest at lsb
    logic [4:0] ones;         // consecutive ones count
    logic [2:0] dropOnes;     // ones before a possible zero deletion
    logic [23:0] dly;         // kept bits, newest at lsb
    logic [7:0] pend;         // newest byte out of the delay line, not yet stored
    logic [15:0] crc;         // running crc
    logic [15:0] bits;        // kept bit count in frame
    logic [2:0] bitCnt;       // bit position in byte
    logic stored;             // a byte of this frame is in the fifo
    logic firstDone;          // first byte already emitted
    logic addrOk;             // address decision
    logic [7:0] firstByte;    // held first byte for address check
    logic holdFirst;          // first byte waiting for address check
    logic ovf;                // overflow truncation active
    logic [1:0] pendTag;      // tag field, never assigned, stays zero
    logic endWr;
    logic endRd;
    logic [15:0] rxCrc;
    logic idle;
    logic ga;
    logic [7:0] outData;
    logic [1:0] outTag;
    logic outVld;
    logic stall;
  } hdlcr_core_t;
  hdlcr_core_t s_reg, s_next;

  // fifo write side
  hdlcr_pkg::hdlcr_entry_t wrEntry;
  logic wrValid, wrReady;
  // fifo read side
  hdlcr_pkg::hdlcr_entry_t rdEntry;
  logic rdValid;
  logic [9:0] rdRaw;

  // next-state temporaries
  logic [8:0] nShf;
  logic keep;
  logic [7:0] byteOut;
  logic [15:0] bcount;
  logic flagHit;
  logic goodCrc;

  // crc step over one bit, lsb first
  function automatic logic [15:0] crcStep(input logic [15:0] cr, input logic b);
    logic fb;
    fb = cr[0] ^ b;
    crcStep = {1'b0, cr[15:1]} ^ (fb ? hdlcr_pkg::CRC_POLY : 16'h0000);
  endfunction

  // address filter on the first one or two bytes
  function automatic logic addrPass(input logic [7:0] a1, input logic [7:0] a2, input logic two,
                                    input logic en, input logic sev, input logic [7:0] m1,
                                    input logic [7:0] m2);
    logic ok1, ok2;
    ok1 = 1'b1;
    ok2 = 1'b1;
    if (!en) begin
      addrPass = 1'b1;
    end else if (two) begin
      // two byte address: six bits of first byte
      if (m1[0]) ok1 = (a1[7:2] == m1[7:2]);
      if (m2[0]) ok2 = (a2 == m2);
      // all-call second byte skips the first
      addrPass = (a2 == hdlcr_pkg::ALL_CALL) ? 1'b1 : (ok1 & ok2);
    end else begin
      // one byte address
      if (m1[0]) ok1 = sev ? (a1[7:1] == m1[7:1]) : (a1[7:2] == m1[7:2]);
      addrPass = (a1 == hdlcr_pkg::ALL_CALL) | ok1;
    end
  endfunction

  // fifo of tagged bytes
  hdlcr_fifo #(
    .WIDTH(hdlcr_pkg::DATA_W + hdlcr_pkg::TAG_W),
    .DEPTH(hdlcr_pkg::FIFO_DEPTH),
    .AW(hdlcr_pkg::FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(soft_link_reset),
    .inData(wrEntry),
    .inValid(wrValid),
    .inReady(wrReady),
    .outData(rdRaw),
    .outValid(rdValid),
    .outReady(fifo_read)
  );
  assign rdEntry = rdRaw;

  // main receive logic
  always_comb begin
    s_next = s_reg;
    wrEntry = '0;
    wrValid = 1'b0;
    nShf = {s_reg.shf[7:0], rx_bit};
    keep = 1'b0;
    byteOut = 8'h00;
    bcount = s_reg.bits;
    flagHit = 1'b0;
    goodCrc = 1'b0;
    if (rx_bit_valid && s_reg.st != hdlcr_pkg::ST_OFF) begin
      s_next.shf = nShf;
      s_next.ones = rx_bit ? ((s_reg.ones == 5'h1F) ? s_reg.ones : s_reg.ones + 5'h01) : 5'h00;
      // idle channel after fifteen ones
      s_next.idle = rx_bit && (s_reg.ones >= (hdlcr_pkg::IDLE_ONES - 5'h01));
      s_next.ga = (nShf == hdlcr_pkg::GOAHEAD_PAT) && (s_reg.st != hdlcr_pkg::ST_FRAME);
      flagHit = (nShf[7:0] == hdlcr_pkg::FLAG_PAT);
      if (s_reg.st == hdlcr_pkg::ST_FRAME) begin
        // zero deletion after five ones
        if (!rx_bit && s_reg.dropOnes == 3'h5) begin
          s_next.dropOnes = 3'h0;
        end else begin
          keep = 1'b1;
          s_next.dropOnes = rx_bit ? ((s_reg.dropOnes == 3'h7) ? 3'h7 : s_reg.dropOnes + 3'h1) : 3'h0;
        end
      end
      if (flagHit) begin
        // closing flag: the last seven kept bits are flag bits, not data
        if (s_reg.st == hdlcr_pkg::ST_FRAME) begin
          bcount = s_reg.bits - 16'h0007;
          goodCrc = (s_reg.crc == hdlcr_pkg::CRC_GOOD);
          // capture check sequence inverted, msb first
          // first check bit sent lands at the msb
          s_next.rxCrc = ~s_reg.dly[22:7];
          if (!s_reg.ovf && bcount >= hdlcr_pkg::MIN_KEEP_BITS) begin
            if (bcount < hdlcr_pkg::FULL_BITS) begin
              // short frame: first byte then bad end
              wrValid = s_reg.addrOk;
              wrEntry.data = s_reg.firstByte;
              wrEntry.tag = s_reg.firstDone ? hdlcr_pkg::TAG_BAD : hdlcr_pkg::TAG_FIRST;
            end else if (s_reg.addrOk && !s_reg.holdFirst) begin
              // final byte ends ahead of the check sequence
              wrValid = 1'b1;
              wrEntry.data = s_reg.pend;
              wrEntry.tag = goodCrc ? hdlcr_pkg::TAG_GOOD : hdlcr_pkg::TAG_BAD;
            end
          end
          // frames under 25 bits write nothing
        end
        // realign and preset crc
        s_next.st = receive_enable || (s_reg.st == hdlcr_pkg::ST_FRAME && s_reg.stored) ?
                    hdlcr_pkg::ST_FRAME : hdlcr_pkg::ST_OFF;
        if (!receive_enable) s_next.st = hdlcr_pkg::ST_OFF;
        s_next.crc = hdlcr_pkg::CRC_INIT;
        s_next.bits = 16'h0000;
        s_next.bitCnt = 3'h0;
        s_next.stored = 1'b0;
        s_next.firstDone = 1'b0;
        s_next.holdFirst = 1'b0;
        s_next.addrOk = 1'b1;
        s_next.ovf = 1'b0;
        s_next.dropOnes = 3'h0;
      end else if (s_reg.st == hdlcr_pkg::ST_FRAME && s_reg.ones >= 5'h06 && rx_bit) begin
        // seven ones: abort; short ones just drop
        if (s_reg.bits >= hdlcr_pkg::ABORT_MIN_BITS && s_reg.stored && !s_reg.ovf) begin
          wrValid = 1'b1;
          wrEntry.data = s_reg.pend;
          wrEntry.tag = hdlcr_pkg::TAG_BAD;
        end
        s_next.st = hdlcr_pkg::ST_HUNT;
      end else if (keep) begin
        s_next.dly = {s_reg.dly[22:0], rx_bit};
        // crc trails by seven kept bits so closing-flag bits never enter it
        if (s_reg.bits >= 16'h0007) s_next.crc = crcStep(s_reg.crc, s_reg.dly[6]);
        s_next.bits = s_reg.bits + 16'h0001;
        s_next.bitCnt = s_reg.bitCnt + 3'h1;
        // a byte leaves the delay line once sixteen bits lag behind
        if (s_reg.bitCnt == 3'h7 && s_reg.bits >= 16'h0017) begin
          // oldest bit on the line is bit 0 of the byte
          byteOut = {<<{s_reg.dly[22:15]}};
          if (!s_reg.firstDone) begin
            s_next.firstByte = byteOut;
            s_next.firstDone = 1'b1;
            s_next.holdFirst = 1'b1;
          end else if (s_reg.holdFirst) begin
            s_next.addrOk = addrPass(s_reg.firstByte, byteOut, ~s_reg.firstByte[0], addr_match_enable,
                                     seven_bit_compare, addr_cmp_first, addr_cmp_second);
            wrValid = s_next.addrOk && !s_reg.ovf;
            wrEntry.data = s_reg.firstByte;
            wrEntry.tag = hdlcr_pkg::TAG_FIRST;
            s_next.holdFirst = 1'b0;
            s_next.pend = byteOut;
          end else if (s_reg.addrOk && !s_reg.ovf) begin
            wrValid = 1'b1;
            wrEntry.data = s_reg.pend;
            wrEntry.tag = hdlcr_pkg::TAG_BODY;
            s_next.pend = byteOut;
          end else begin
            s_next.pend = byteOut;
          end
        end
      end
      // disable waits only while part of a packet is stored
      if (!receive_enable && !s_reg.stored && !flagHit) s_next.st = hdlcr_pkg::ST_OFF;
    end else if (s_reg.st == hdlcr_pkg::ST_OFF && receive_enable) begin
      // enabling starts a hunt for a flag
      s_next.st = hdlcr_pkg::ST_HUNT;
      s_next.shf = 9'h1FF;
    end else if (!receive_enable && !s_reg.stored) begin
      s_next.st = hdlcr_pkg::ST_OFF;
    end
    // overflow: drop rest, no end tag, top byte kept
    if (wrValid && !wrReady) begin
      s_next.ovf = 1'b1;
      wrValid = 1'b0;
    end
    if (wrValid) begin
      s_next.stored = (wrEntry.tag == hdlcr_pkg::TAG_FIRST) || (wrEntry.tag == hdlcr_pkg::TAG_BODY);
      // end-written flag tracks newest stored byte
      s_next.endWr = wrEntry.tag[1];
    end
    if (s_next.ovf) s_next.stored = 1'b0;
    // status of the byte at fifo output, kept while disabled
    s_next.outVld = rdValid;
    s_next.outData = rdEntry.data;
    s_next.outTag = rdValid ? rdEntry.tag : 2'h0;
    s_next.endRd = rdValid & rdEntry.tag[1];
    s_next.stall = ~wrReady;
    if (soft_link_reset) s_next = '0;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) s_reg <= '0;
    else s_reg <= s_next;
  end

  // outputs straight from state
  assign fifo_data = s_reg.outData;
  assign first_byte_tag = s_reg.outTag[0];
  assign last_byte_tag = s_reg.outTag[1];
  assign fifo_not_empty = s_reg.outVld;
  assign end_written_irq = s_reg.endWr;
  assign end_read_irq = s_reg.endRd;
  assign rx_crc = s_reg.rxCrc;
  assign frame_active = (s_reg.st == hdlcr_pkg::ST_FRAME);
  assign idle_channel = s_reg.idle;
  assign go_ahead_seen = s_reg.ga;
  assign fifo_stall = s_reg.stall;

  // idle rises only right after a one was received
  AST_IDLE_ONES: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(idle_channel) |-> $past(rx_bit)) else $error("idle without ones");
  // end-read status only with a byte present
  AST_END_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    end_read_irq |-> fifo_not_empty && last_byte_tag) else $error("end read without end byte");
  // end tag written only inside a frame
  AST_TAG_CODE: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrValid && wrEntry.tag[1] |-> s_reg.st == hdlcr_pkg::ST_FRAME) else $error("end tag outside frame");
  // no write into a full fifo
  AST_NO_OVERWRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrValid |-> wrReady) else $error("write into full fifo");
  // disabled receiver stores nothing
  AST_OFF_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_reg.st == hdlcr_pkg::ST_OFF |-> !wrValid) else $error("write while off");
  // flag resets the bit count
  AST_FLAG_ALIGN: assert property (@(posedge core_clk) disable iff (!rst_n || soft_link_reset)
    rx_bit_valid && flagHit && s_reg.st != hdlcr_pkg::ST_OFF |=> s_reg.bits == 16'h0000) else $error("no align");
  // overflow lasts until a flag
  AST_OVF_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n || soft_link_reset)
    s_reg.ovf && !(rx_bit_valid && flagHit) |=> s_reg.ovf) else $error("overflow cleared early");
  // end-written follows the end tag written
  AST_END_WRITTEN: assert property (@(posedge core_clk) disable iff (!rst_n || soft_link_reset)
    wrValid && wrEntry.tag[1] |=> end_written_irq) else $error("end written missing");
endmodule

// File: verilog/hdlcr_fifo.sv
// small valid/ready fifo used in the receive data path
`timescale 1ns/1ps
module hdlcr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  // pointers carry one extra wrap bit
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } hdlcr_fptr_t;
  hdlcr_fptr_t st_reg, st_next;
  logic full, empty, doWr, doRd;

  // full when wrap bits differ and indices match
  assign full = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
  assign empty = st_reg.wp == st_reg.rp;
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = mem[st_reg.rp[AW-1:0]];
  assign doWr = inValid & ~full;
  assign doRd = outReady & ~empty;

  // pointer update
  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.wp = '0;
      st_next.rp = '0;
    end else begin
      if (doWr) st_next.wp = st_reg.wp + 1'b1;
      if (doRd) st_next.rp = st_reg.rp + 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) st_reg <= '0;
    else st_reg <= st_next;
  end

  // data write; the byte at the output is never overwritten since full blocks writes
  always_ff @(posedge core_clk) begin
    if (doWr && !clr) mem[st_reg.wp[AW-1:0]] <= inData;
  end
endmodule

// File: verilog/hdlcr_pkg.sv
// package of constants and types for the hdlc packet receiver
package hdlcr_pkg;
  localparam int DATA_W = 8; // data byte width
  localparam int TAG_W = 2; // status tag width
  localparam int FIFO_DEPTH = 16; // receive fifo depth
  localparam int FIFO_AW = 4; // fifo address width
  localparam logic [15:0] CRC_INIT = 16'hFFFF; // crc preset value
  localparam logic [15:0] CRC_GOOD = 16'hF0B8; // residue of a good frame
  localparam logic [15:0] CRC_POLY = 16'h8408; // reflected crc-16 polynomial
  localparam logic [7:0] FLAG_PAT = 8'h7E; // flag pattern
  localparam logic [8:0] GOAHEAD_PAT = 9'h0FE; // go-ahead pattern, newest bit at lsb
  localparam logic [4:0] IDLE_ONES = 5'h0F; // ones for idle channel
  localparam logic [2:0] ABORT_ONES = 3'h7; // ones for abort
  localparam logic [15:0] MIN_KEEP_BITS = 16'h0019; // least bits kept between flags
  localparam logic [15:0] FULL_BITS = 16'h0020; // bits for a full minimum frame
  localparam logic [15:0] ABORT_MIN_BITS = 16'h001A; // least bits for an abort
  localparam logic [1:0] TAG_BODY = 2'h0; // packet byte
  localparam logic [1:0] TAG_FIRST = 2'h1; // first byte
  localparam logic [1:0] TAG_GOOD = 2'h2; // last byte of good packet
  localparam logic [1:0] TAG_BAD = 2'h3; // last byte of bad packet
  localparam logic [7:0] ALL_CALL = 8'hFF; // all-call address byte

  // one fifo entry: byte plus tag
  typedef struct packed {
    logic [1:0] tag;
    logic [7:0] data;
  } hdlcr_entry_t;

  // receiver states
  typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_FRAME, ST_DROP} hdlcr_state_t;
endpackage
